// ---- pkg/timer_pkg.sv ----
// Package for the gated prescaled interval timer.
// Assumes a 32-bit APB slave, one aligned word per register.
package timer_pkg;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFF     = 8'h00;
    localparam logic [7:0]  COUNT_OFF    = 8'h04;
    localparam logic [7:0]  PERIOD_OFF   = 8'h08;
    localparam logic [7:0]  STATUS_OFF   = 8'h0c;
    localparam logic [7:0]  MASK_OFF     = 8'h10;
    localparam logic [7:0]  PRIO_OFF     = 8'h14;

    // Control field positions
    localparam int          RUN_BIT      = 15;
    localparam int          IDLE_BIT     = 13;
    localparam int          GATE_BIT     = 6;
    localparam int          PS_LSB       = 4;
    localparam int          SYNC_BIT     = 2;
    localparam int          CS_BIT       = 1;
    localparam logic [15:0] CTRL_WMASK   = 16'ha076;

    // Status and mask field positions
    localparam int          MATCH_BIT    = 0;
    localparam int          GFALL_BIT    = 1;
    localparam int          EV_W         = 2;

    // Reset values
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [2:0]  PRIO_RESET   = 3'h0;

    // Prescale codes
    localparam logic [1:0]  PS_1         = 2'h0;
    localparam logic [1:0]  PS_8         = 2'h1;
    localparam logic [1:0]  PS_64        = 2'h2;
    localparam logic [1:0]  PS_256       = 2'h3;

    // Terminal prescaler count for a prescale code
    function automatic logic [7:0] prescale_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = 8'h00;
        case (sel)
            PS_8:    lim = 8'h07;
            PS_64:   lim = 8'h3f;
            PS_256:  lim = 8'hff;
            default: lim = 8'h00;
        endcase
        return lim;
    endfunction : prescale_limit

endpackage : timer_pkg

// ---- rtl/pin_edge.sv ----
// Edge detector for a pin, with an optional two-stage synchroniser.
// Assumes the pin is sampled on pclk; sync_en picks the path.
`timescale 1ns/10ps
`default_nettype none
module pin_edge
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and option
    input  wire logic pin,
    input  wire logic sync_en,
    // Edges
    output logic      rise,
    output logic      fall
);

    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic prev_q, prev_d;
    logic cur;

    // Synchroniser chain and last sampled level
    always_comb
    begin
        s1_d   = pin;
        s2_d   = s1_q;
        prev_d = cur;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
        end
    end

    // Level seen by the edge logic
    assign cur  = sync_en ? s2_q : pin;
    assign rise = cur & ~prev_q;
    assign fall = ~cur & prev_q;

endmodule : pin_edge
`default_nettype wire

// ---- rtl/prescaler.sv ----
// Prescaler: passes one in every limit+1 input ticks.
// Assumes limit is steady while counting; clear restarts the cycle.
`timescale 1ns/10ps
`default_nettype none
module prescaler
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [7:0] limit,
    // Output tick
    output logic            carry
);

    logic [7:0] cnt_q, cnt_d;

    // Terminal count reached on an input tick
    assign carry = tick & (cnt_q >= limit);

    always_comb
    begin
        cnt_d = cnt_q;
        if (clear)
            cnt_d = 8'h00;
        else if (carry)
            cnt_d = 8'h00;
        else if (tick)
            cnt_d = cnt_q + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end

endmodule : prescaler
`default_nettype wire

// ---- rtl/interval_timer.sv ----
// Top of the gated prescaled 16-bit interval timer with APB registers.
// Assumes pins are synchronous to pclk, which is the internal clock.
//
// Behaviour
// - The counter is 16 bits and runs as timer, sync or async counter.
// - A match pulse serves as a clock time base or a free interval.
// - Interrupt on a period match or on the gate falling in gated mode.
// - Gate bit 6 enables gated accumulation only with internal clock.
// - Prescale bits 5-4 divide by 1, 8, 64 or 256 for codes 0 to 3.
// - Sync bit 2 synchronises the external clock, ignored if internal.
// - Source bit 1 picks the pin rising edge or the internal clock.
// - The counter can keep running in idle and in sleep.
// - Unused control bits 14, 12-7, 3 and 0 read zero, drop writes.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module interval_timer
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        ext_clk_pin,
    input  wire logic        gate_pin,
    // Power state
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    // Outputs
    output logic             irq,
    output logic      [2:0]  irq_priority,
    output logic             rtc_tick
);

    logic [15:0]     ctrl_q, ctrl_d;
    logic [15:0]     count_q, count_d;
    logic [15:0]     period_q, period_d;
    logic [EV_W-1:0] status_q, status_d;
    logic [EV_W-1:0] mask_q, mask_d;
    logic [2:0]      prio_q, prio_d;
    logic [31:0]     rdata_q, rdata_d;
    logic            rtc_q, rtc_d;

    logic            setup, wr, mapped;
    logic            wr_ctrl, wr_count, wr_period;
    logic            wr_status, wr_mask, wr_prio;
    logic            ext_sel, gate_en, async_ext, run;
    logic            ext_rise, gate_fall;
    logic            raw_tick, cnt_tick, match_ev, gate_ev;
    logic [EV_W-1:0] events;
    logic [31:0]     rd_word;

    // APB phase decode; zero wait states
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = rdata_q;

    // Address decode
    always_comb
    begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr == CTRL_OFF)
            rd_word = {16'h0000, ctrl_q};
        else if (paddr == COUNT_OFF)
            rd_word = {16'h0000, count_q};
        else if (paddr == PERIOD_OFF)
            rd_word = {16'h0000, period_q};
        else if (paddr == STATUS_OFF)
            rd_word = {30'h0, status_q};
        else if (paddr == MASK_OFF)
            rd_word = {30'h0, mask_q};
        else if (paddr == PRIO_OFF)
            rd_word = {29'h0, prio_q};
        else
            mapped = 1'b0;
    end

    // Write strobes, taken in the access phase
    assign wr_ctrl   = wr & (paddr == CTRL_OFF);
    assign wr_count  = wr & (paddr == COUNT_OFF);
    assign wr_period = wr & (paddr == PERIOD_OFF);
    assign wr_status = wr & (paddr == STATUS_OFF);
    assign wr_mask   = wr & (paddr == MASK_OFF);
    assign wr_prio   = wr & (paddr == PRIO_OFF);

    // Clock source and gating selection
    assign ext_sel   = ctrl_q[CS_BIT];
    assign gate_en   = ctrl_q[GATE_BIT] & ~ext_sel;
    assign async_ext = ext_sel & ~ctrl_q[SYNC_BIT];

    // Run qualifier: run bit, idle halt, sleep keeps only async counting
    assign run = ctrl_q[RUN_BIT]
               & ~(idle_mode & ctrl_q[IDLE_BIT])
               & ~(sleep_mode & ~async_ext);

    // External clock pin edges, synchroniser only when asked
    pin_edge u_ext_edge
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_clk_pin),
        .sync_en (ctrl_q[SYNC_BIT] & ext_sel),
        .rise    (ext_rise),
        .fall    ()
    );

    // Gate pin edges
    pin_edge u_gate_edge
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (gate_pin),
        .sync_en (1'b0),
        .rise    (),
        .fall    (gate_fall)
    );

    // Raw count source: pin edge, gated internal clock, or internal clock
    always_comb
    begin
        if (ext_sel)
            raw_tick = ext_rise;
        else if (gate_en)
            raw_tick = gate_pin;
        else
            raw_tick = 1'b1;
    end

    // Prescaler; restarted when software loads the count
    prescaler u_prescaler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (run & raw_tick),
        .clear   (wr_count),
        .limit   (prescale_limit(ctrl_q[PS_LSB +: 2])),
        .carry   (cnt_tick)
    );

    // Events
    assign match_ev = cnt_tick & (count_q == period_q);
    assign gate_ev  = gate_en & ctrl_q[RUN_BIT] & gate_fall;
    always_comb
    begin
        events            = '0;
        events[MATCH_BIT] = match_ev;
        events[GFALL_BIT] = gate_ev;
    end

    // Control, period, mask and priority registers
    always_comb
    begin
        ctrl_d   = ctrl_q;
        period_d = period_q;
        mask_d   = mask_q;
        prio_d   = prio_q;
        if (wr_ctrl)
            ctrl_d = pwdata[15:0] & CTRL_WMASK;
        if (wr_period)
            period_d = pwdata[15:0];
        if (wr_mask)
            mask_d = pwdata[EV_W-1:0];
        if (wr_prio)
            prio_d = pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= CTRL_RESET;
            period_q <= PERIOD_RESET;
            mask_q   <= '0;
            prio_q   <= PRIO_RESET;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            period_q <= period_d;
            mask_q   <= mask_d;
            prio_q   <= prio_d;
        end
    end

    // Counter: software load wins, else wrap on match or increment
    always_comb
    begin
        count_d = count_q;
        if (wr_count)
            count_d = pwdata[15:0];
        else if (match_ev)
            count_d = COUNT_RESET;
        else if (cnt_tick)
            count_d = count_q + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= COUNT_RESET;
        else
            count_q <= count_d;
    end

    // Sticky status, write one to clear, a new event wins
    always_comb
    begin
        status_d = status_q;
        if (wr_status)
            status_d = status_q & ~pwdata[EV_W-1:0];
        status_d = status_d | events;
    end

    // Read data, time base pulse
    always_comb
    begin
        rdata_d = rdata_q;
        if (setup & ~pwrite)
            rdata_d = rd_word;
        rtc_d = match_ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= '0;
            rdata_q  <= 32'h0000_0000;
            rtc_q    <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            rdata_q  <= rdata_d;
            rtc_q    <= rtc_d;
        end
    end

    // Outputs
    assign irq          = |(status_q & mask_q);
    assign irq_priority = prio_q;
    assign rtc_tick     = rtc_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ctrl_reserved: assert property (
        (ctrl_q & ~CTRL_WMASK) == 16'h0000)
        else $error("reserved control bits not zero");

    a_run_stops: assert property (
        !ctrl_q[RUN_BIT] && !wr_count |=> $stable(count_q))
        else $error("count moved while stopped");

    a_idle_halt: assert property (
        idle_mode && ctrl_q[IDLE_BIT] && !wr_count |=> $stable(count_q))
        else $error("count moved in idle with halt set");

    a_match_wrap: assert property (
        match_ev && !wr_count |=> count_q == 16'h0000
                                  && status_q[MATCH_BIT] && rtc_tick)
        else $error("match did not wrap and flag");

    a_gate_flag: assert property (
        gate_ev |=> status_q[GFALL_BIT])
        else $error("gate fall not flagged");

    a_ext_no_gate: assert property (
        ext_sel |-> !gate_ev)
        else $error("gate event with external clock");

    a_div_one: assert property (
        run && !ext_sel && !gate_en && ctrl_q[PS_LSB +: 2] == PS_1
        && !wr_count |-> cnt_tick)
        else $error("1:1 prescale missed a tick");

    a_div_eight: assert property (
        cnt_tick && ctrl_q[PS_LSB +: 2] == PS_8 && !wr_ctrl
        |=> !cnt_tick [*7])
        else $error("1:8 prescale ticked early");

    a_sleep_async: assert property (
        sleep_mode && ctrl_q[RUN_BIT] && async_ext && ext_rise
        && !(idle_mode && ctrl_q[IDLE_BIT])
        && ctrl_q[PS_LSB +: 2] == PS_1 |-> cnt_tick)
        else $error("async counter stalled in sleep");

    a_sleep_int: assert property (
        sleep_mode && !async_ext && !wr_count |=> $stable(count_q))
        else $error("internal count ran in sleep");

    c_match:    cover property (match_ev);
    c_gate:     cover property (gate_ev);
    c_irq:      cover property ($rose(irq));
    c_sleep_ex: cover property (sleep_mode && async_ext && cnt_tick);

endmodule : interval_timer
`default_nettype wire

// ---- verification/pin_source.sv ----
// Behavioural source for the external count clock and gate pins.
// Assumes the bench calls its tasks; pins change after a rising pclk.
`timescale 1ns/10ps
`default_nettype none
module pin_source
(
    // Clock
    input  wire logic pclk,
    // Pins
    output var  logic ext_clk_pin,
    output var  logic gate_pin
);
    // Both pins idle low
    initial
    begin
        ext_clk_pin = 1'b0;
        gate_pin    = 1'b0;
    end

    // Rising edges two cycles high, two low; clock stands low after
    task automatic clock_edges(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ext_clk_pin <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_clk_pin <= 1'b0;
            @(posedge pclk);
        end
    endtask : clock_edges

    // Gate high for len cycles, then a falling edge
    task automatic gate_pulse(input int len);
        @(posedge pclk);
        gate_pin <= 1'b1;
        repeat (len) @(posedge pclk);
        gate_pin <= 1'b0;
    endtask : gate_pulse
endmodule : pin_source
`default_nettype wire

// ---- verification/interval_timer_test.sv ----
// Self-checking bench for the interval timer through its APB port.
// Assumes zero-wait APB and the pin source model on the pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
    begin \
        cmp_count++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("[FAIL] %0t got %h exp %h", $time, a, b); \
        end \
    end
module interval_timer_test;
    import timer_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, q2;
    logic        pready, pslverr, ext_clk_pin, gate_pin;
    logic        idle_mode, sleep_mode, irq, rtc_tick, last_err;
    logic [2:0]  irq_priority;
    int          errors, cmp_count, n;

    // Design and pin source
    interval_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .gate_pin(gate_pin), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode), .irq(irq),
        .irq_priority(irq_priority), .rtc_tick(rtc_tick));
    pin_source src (.pclk(pclk), .ext_clk_pin(ext_clk_pin),
        .gate_pin(gate_pin));

    // 250 MHz clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            errors++;
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Cycles up to the next rate tick, sampled mid-cycle
    task automatic wait_tick;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (rtc_tick !== 1'b1 && n < 2000);
        // No rate tick within the limit counts as a mismatch
        if (rtc_tick !== 1'b1)
            errors++;
    endtask : wait_tick

    // Reset values, dropped control bits, unmapped address, priority
    task automatic t_regs;
        logic [7:0]  offs [6] = '{CTRL_OFF, COUNT_OFF, PERIOD_OFF,
                                  STATUS_OFF, MASK_OFF, PRIO_OFF};
        logic [31:0] rv [6] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0,
                                32'h0};
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, offs[i], 32'h0);
            `CHK(q, rv[i])
        end
        `CHK(irq, 1'b0)
        wr(CTRL_OFF, 32'hffffffff);
        apb(1'b0, CTRL_OFF, 32'h0);
        `CHK(q, 32'h0000a076)
        wr(CTRL_OFF, 32'h0);
        wr(8'h20, 32'h5a5a5a5a);
        `CHK(last_err, 1'b1)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(q, 32'h0)
        wr(PRIO_OFF, 32'h5);
        @(negedge pclk);
        `CHK(irq_priority, 3'h5)
    endtask : t_regs

    // Match period for every prescale code, then the interrupt path
    task automatic t_prescale;
        int div [4] = '{1, 8, 64, 256};
        wr(MASK_OFF, 32'h1);
        wr(PERIOD_OFF, 32'h3);
        for (int c = 0; c < 4; c++)
        begin
            wr(COUNT_OFF, 32'h0);
            wr(CTRL_OFF, 32'h8000 | (c << PS_LSB));
            wait_tick();
            `CHK(irq, 1'b1)
            wait_tick();
            `CHK(n, 4 * div[c])
            wr(CTRL_OFF, 32'h0);
        end
        apb(1'b0, STATUS_OFF, 32'h0);
        `CHK(q, 32'h1)
        wr(MASK_OFF, 32'h0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        wr(MASK_OFF, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        wr(STATUS_OFF, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b0)
    endtask : t_prescale

    // Gated accumulation and the gate-fall event
    task automatic t_gate;
        wr(PERIOD_OFF, 32'hffff);
        wr(CTRL_OFF, 32'h8040);
        wr(COUNT_OFF, 32'h0);
        src.gate_pulse(10);
        repeat (4) @(posedge pclk);
        apb(1'b0, COUNT_OFF, 32'h0);
        `CHK(q, 32'ha)
        apb(1'b0, STATUS_OFF, 32'h0);
        `CHK(q, 32'h2)
        wr(STATUS_OFF, 32'h3);
    endtask : t_gate

    // External clock, async and sync, sleep, gate ignored
    task automatic t_ext(input logic [31:0] ctrl, input logic slp,
                         input logic [31:0] exp);
        wr(CTRL_OFF, ctrl);
        wr(COUNT_OFF, 32'h0);
        sleep_mode <= slp;
        src.clock_edges(5);
        src.gate_pulse(3);
        repeat (6) @(posedge pclk);
        sleep_mode <= 1'b0;
        apb(1'b0, COUNT_OFF, 32'h0);
        `CHK(q, exp)
        apb(1'b0, STATUS_OFF, 32'h0);
        `CHK(q, 32'h0)
    endtask : t_ext

    // Idle halt, running through idle, run bit cleared
    task automatic t_idle;
        idle_mode <= 1'b1;
        wr(CTRL_OFF, 32'ha000);
        wr(COUNT_OFF, 32'h0);
        repeat (20) @(posedge pclk);
        apb(1'b0, COUNT_OFF, 32'h0);
        `CHK(q, 32'h0)
        wr(CTRL_OFF, 32'h8000);
        apb(1'b0, COUNT_OFF, 32'h0);
        q2 = q;
        apb(1'b0, COUNT_OFF, 32'h0);
        `CHK(q != q2, 1'b1)
        idle_mode <= 1'b0;
        wr(CTRL_OFF, 32'h0);
        apb(1'b0, COUNT_OFF, 32'h0);
        q2 = q;
        apb(1'b0, COUNT_OFF, 32'h0);
        `CHK(q, q2)
    endtask : t_idle

    // Verdict and end of run
    task automatic wrap_up;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Watchdog against a hang
    initial
    begin
        repeat (50000) @(posedge pclk);
        errors++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, idle_mode, sleep_mode} = '0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_prescale();
        t_gate();
        t_ext(32'h8042, 1'b0, 32'h5);
        t_ext(32'h8006, 1'b0, 32'h5);
        t_ext(32'h8002, 1'b1, 32'h5);
        t_ext(32'h8006, 1'b1, 32'h0);
        t_idle();
        wrap_up();
    end
endmodule : interval_timer_test
`default_nettype wire
